// file: hw/bti_pkg.sv
// package: register map, field positions and reset values of the
// bar translation and interrupt signalling block.
// assumes a 32-bit register port with byte addresses.
package bti_pkg;

	// ======================================================
	// register offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_DECODE    = 8'h04;
	localparam logic [7:0] OFS_MASK      = 8'h08;
	localparam logic [7:0] OFS_MSG_ADDR0 = 8'h0c;
	localparam logic [7:0] OFS_MSG_ADDR1 = 8'h10;
	localparam logic [7:0] OFS_MSG_DATA  = 8'h14;
	localparam logic [7:0] OFS_STATUS    = 8'h18;
	localparam logic [7:0] OFS_WIN_FIRST = 8'h40;
	localparam int         WIN_STRIDE_SH = 3;
	localparam int         WIN_HI_SEL    = 2;

	// ======================================================
	// control fields
	localparam int         CTRL_MSG_EN   = 0;
	localparam int         CTRL_ERR_REP  = 1;
	localparam int         CTRL_PIN_LO   = 4;
	localparam int         PIN_W         = 3;
	localparam logic [2:0] PIN_INTA      = 3'h1;
	localparam logic [2:0] PIN_NONE      = 3'h0;

	// ======================================================
	// decode and mask bits
	localparam int         DEC_W         = 3;
	localparam int         DEC_MSG_RX    = 0;
	localparam int         DEC_POISON    = 1;
	localparam int         DEC_MALFORMED = 2;

	// ======================================================
	// status fields
	localparam int         STS_LEVEL     = 0;
	localparam int         STS_ASSERTED  = 1;
	localparam int         STS_RC        = 2;

	// ======================================================
	// reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [DEC_W-1:0] MASK_RST = 3'h0;
	localparam logic [31:0] MSG_RST      = 32'h0000_0000;

	typedef enum logic [1:0] {
		LEG_IDLE     = 2'b01,
		LEG_ASSERTED = 2'b10
	} bti_leg_t;

endpackage

// file: hw/bti_outbound.sv
// outbound translation: local window hit and pcie address rewrite.
// assumes windows are power-of-two sized and aligned to their size.
`timescale 1ns/1ns
module bti_outbound #(
	parameter int          COUNT = 6,
	parameter logic [191:0] BASE = 192'h0,
	parameter logic [191:0] HIGH = {6{32'h0000_ffff}},
	parameter logic [5:0]  WIDE  = 6'h0
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic [31:0]         addr_in,
	input  wire logic                valid_in,
	input  wire logic [COUNT*64-1:0] xlate_in,
	output logic      [63:0]         addr_out,
	output logic                     hit_out,
	output logic                     wide_out,
	output logic                     valid_out
);
	logic [63:0] addr_d;
	logic        hit_d;
	logic        wide_d;
	logic [31:0] m;
	logic [63:0] v;

	// ======================================================
	// window select, lowest window wins
	always_comb begin
		addr_d = 64'h0;
		hit_d  = 1'b0;
		wide_d = 1'b0;
		m      = 32'h0;
		v      = 64'h0;
		for (int i = COUNT - 1; i >= 0; i--) begin
			if (addr_in >= BASE[i*32 +: 32] &&
			    addr_in <= HIGH[i*32 +: 32]) begin
				m      = HIGH[i*32 +: 32] - BASE[i*32 +: 32];
				v      = xlate_in[i*64 +: 64];
				hit_d  = 1'b1;
				wide_d = WIDE[i];
				addr_d[31:0] = (v[31:0] & ~m) | (addr_in & m);
				addr_d[63:32] = WIDE[i] ? v[63:32] : 32'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_out  <= 64'h0;
			hit_out   <= 1'b0;
			wide_out  <= 1'b0;
			valid_out <= 1'b0;
		end else begin
			addr_out  <= addr_d;
			hit_out   <= hit_d & valid_in;
			wide_out  <= wide_d;
			valid_out <= valid_in;
		end
	end
endmodule

// file: hw/bti_inbound.sv
// inbound translation: pcie address in a bar to a 32-bit axi address.
// assumes the bar hit vector is one-hot and the length fits the base.
`timescale 1ns/1ns
module bti_inbound #(
	parameter int          COUNT = 3,
	parameter logic [23:0] LEN   = {3{8'd16}},
	parameter logic [95:0] BASE  = 96'h0
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [63:0]      addr_in,
	input  wire logic [COUNT-1:0] bar_hit,
	input  wire logic             valid_in,
	output logic      [31:0]      addr_out,
	output logic                  valid_out
);
	logic [31:0] addr_d;
	logic [31:0] m;

	// ======================================================
	// keep the low bits, upper bits from the bar base
	always_comb begin
		addr_d = 32'h0;
		m      = 32'h0;
		for (int i = 0; i < COUNT; i++) begin
			if (bar_hit[i]) begin
				m = (32'h1 << LEN[i*8 +: 8]) - 32'h1;
				addr_d = (BASE[i*32 +: 32] & ~m) |
				         (addr_in[31:0] & m);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_out  <= 32'h0;
			valid_out <= 1'b0;
		end else begin
			addr_out  <= addr_d;
			valid_out <= valid_in & (|bar_hit);
		end
	end
endmodule

// file: hw/bti_top.sv
// top: bar translation, local interrupt, msi and legacy interrupt
// signalling, malformed and poisoned tlp reporting.
// assumes every input is synchronous to CLK, pulses are one cycle.
//
// Functional notes
// - window low bits pass, upper bits from vector
// - up to six local windows, each width selectable
// - dynamic mode lets software rewrite vectors
// - inbound keeps low L bits, upper from base
// - inbound and outbound translation fully independent
// - interrupt out only for unmasked sources
// - msi received source used only as root complex
// - msi enabled: request edge sends msi write
// - request input synchronous, rising edge detected
// - msi address and data from config registers
// - request input ignored in root complex mode
// - legacy pin select nonzero only as endpoint
// - legacy rise sends assert inta message
// - legacy fall sends deassert inta message
// - endpoint malformed tlp sends fatal if enabled
// - root port drops poisoned request, sets flag
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module bti_top
	import bti_pkg::*;
#(
	parameter bit          ROOT_COMPLEX_SELECT = 1'b0,
	parameter bit          DYNAMIC_XLATE_SELECT = 1'b0,
	parameter int          LOCAL_WINDOW_COUNT = 6,
	parameter logic [191:0] LOCAL_WINDOW_BASE = {64'h0, 32'h0,
		32'hfe00_0000, 32'habcd_e000, 32'h1234_0000},
	parameter logic [191:0] LOCAL_WINDOW_HIGH = {64'h0, 32'h7f,
		32'hffff_ffff, 32'habcd_ffff, 32'h1234_ffff},
	parameter logic [5:0]  LOCAL_WINDOW_WIDE_SPACE = 6'h0a,
	parameter logic [383:0] LOCAL_WINDOW_XLATE_VECTOR = {128'h0,
		64'h6000_0000_8765_4380, 64'h4000_0000,
		64'h5000_0000_fedc_0000, 64'h5671_0000},
	parameter int          INBOUND_BAR_COUNT = 3,
	parameter logic [23:0] INBOUND_BAR_LEN_BITS = {8'd16, 8'd25, 8'd15},
	parameter logic [95:0] INBOUND_BAR_XLATE_BASE = {32'h0, 32'hfe00_0000,
		32'h1234_0000}
) (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	input  wire logic [31:0] AXI_ADDR,
	input  wire logic        AXI_ADDR_VALID,
	output logic      [63:0] PCIE_ADDR,
	output logic             PCIE_ADDR_HIT,
	output logic             PCIE_ADDR_WIDE,
	output logic             PCIE_ADDR_VALID,
	input  wire logic [63:0] RX_PCIE_ADDR,
	input  wire logic [INBOUND_BAR_COUNT-1:0] RX_BAR_HIT,
	input  wire logic        RX_ADDR_VALID,
	output logic      [31:0] RX_AXI_ADDR,
	output logic             RX_AXI_ADDR_VALID,
	input  wire logic        IRQ_REQUEST_IN,
	input  wire logic        MSG_IRQ_RECEIVED,
	input  wire logic        MALFORMED_TLP,
	input  wire logic        POISONED_REQ,
	output logic             MSG_IRQ_ENABLED,
	output logic             MSG_IRQ_REQUEST,
	output logic      [63:0] MSG_IRQ_ADDR,
	output logic      [31:0] MSG_IRQ_DATA,
	output logic             ASSERT_INTA_MSG,
	output logic             DEASSERT_INTA_MSG,
	output logic             FATAL_ERR_MSG,
	output logic             DROP_POISONED_TLP,
	output logic             INTERRUPT_OUT
);
	localparam int NW = LOCAL_WINDOW_COUNT;

	// ======================================================
	// parameter checks
	if (NW < 1 || NW > 6) begin : g_bad_windows
		$error("local window count must be 1 to 6");
	end
	if (INBOUND_BAR_COUNT < 1 || INBOUND_BAR_COUNT > 3) begin : g_bad_bars
		$error("inbound bar count must be 1 to 3");
	end

	logic [31:0]      ctrl_q;
	logic [DEC_W-1:0] decode_q;
	logic [DEC_W-1:0] decode_d;
	logic [DEC_W-1:0] mask_q;
	logic [31:0]      msg_addr0_q;
	logic [31:0]      msg_addr1_q;
	logic [31:0]      msg_data_q;
	logic [NW*64-1:0] xlate_q;
	logic [31:0]      rdata_d;
	logic             req_prev_q;
	logic             req_rise;
	logic             req_fall;
	logic             ep_mode;
	logic             msg_en;
	logic             legacy_sel;
	logic             irq_q;
	logic             win_sel;
	logic [7:0]       win_ofs;
	logic [2:0]       win_idx;
	bti_leg_t         leg_q;

	assign ep_mode    = !ROOT_COMPLEX_SELECT;
	assign msg_en     = ctrl_q[CTRL_MSG_EN];
	assign legacy_sel = ctrl_q[CTRL_PIN_LO +: PIN_W] == PIN_INTA;
	assign win_ofs    = REG_ADDR - OFS_WIN_FIRST;
	assign win_idx    = win_ofs[WIN_STRIDE_SH +: 3];
	assign win_sel    = REG_ADDR >= OFS_WIN_FIRST &&
	                    32'(win_idx) < NW && win_ofs[1:0] == 2'b00 &&
	                    win_ofs[7:6] == 2'b00;

	// ======================================================
	// control register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_q <= CTRL_RST;
		end else if (REG_WR && REG_ADDR == OFS_CTRL) begin
			ctrl_q <= 32'h0;
			ctrl_q[CTRL_MSG_EN]  <= REG_WDATA[CTRL_MSG_EN] & ep_mode;
			ctrl_q[CTRL_ERR_REP] <= REG_WDATA[CTRL_ERR_REP];
			ctrl_q[CTRL_PIN_LO +: PIN_W] <= ep_mode ?
				REG_WDATA[CTRL_PIN_LO +: PIN_W] : PIN_NONE;
		end
	end

	// ======================================================
	// mask register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mask_q <= MASK_RST;
		end else if (REG_WR && REG_ADDR == OFS_MASK) begin
			mask_q <= REG_WDATA[DEC_W-1:0];
			mask_q[DEC_MSG_RX] <= REG_WDATA[DEC_MSG_RX] &
			                      ROOT_COMPLEX_SELECT;
		end
	end

	// ======================================================
	// msi address and data, written by the root complex
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			msg_addr0_q <= MSG_RST;
			msg_addr1_q <= MSG_RST;
			msg_data_q  <= MSG_RST;
		end else if (REG_WR) begin
			if (REG_ADDR == OFS_MSG_ADDR0) begin
				msg_addr0_q <= REG_WDATA;
			end
			if (REG_ADDR == OFS_MSG_ADDR1) begin
				msg_addr1_q <= REG_WDATA;
			end
			if (REG_ADDR == OFS_MSG_DATA) begin
				msg_data_q <= REG_WDATA;
			end
		end
	end

	// ======================================================
	// translation vectors, writable only in dynamic mode
	for (genvar n = 0; n < NW; n++) begin : g_win
		always_ff @(posedge CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				xlate_q[n*64 +: 64] <= LOCAL_WINDOW_XLATE_VECTOR[n*64 +: 64];
			end else if (DYNAMIC_XLATE_SELECT && REG_WR && win_sel &&
			             32'(win_idx) == n) begin
				if (win_ofs[WIN_HI_SEL]) begin
					xlate_q[n*64+32 +: 32] <= REG_WDATA;
				end else begin
					xlate_q[n*64 +: 32] <= REG_WDATA;
				end
			end
		end
	end

	// ======================================================
	// interrupt decode, write one to clear, set wins
	always_comb begin
		decode_d = decode_q;
		if (REG_WR && REG_ADDR == OFS_DECODE) begin
			decode_d = decode_q & ~REG_WDATA[DEC_W-1:0];
		end
		if (MSG_IRQ_RECEIVED && ROOT_COMPLEX_SELECT) begin
			decode_d[DEC_MSG_RX] = 1'b1;
		end
		if (POISONED_REQ && ROOT_COMPLEX_SELECT) begin
			decode_d[DEC_POISON] = 1'b1;
		end
		if (MALFORMED_TLP) begin
			decode_d[DEC_MALFORMED] = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			decode_q <= '0;
			irq_q    <= 1'b0;
		end else begin
			decode_q <= decode_d;
			irq_q    <= |(decode_q & mask_q);
		end
	end

	// ======================================================
	// request edge detect and message generation
	assign req_rise = IRQ_REQUEST_IN & !req_prev_q;
	assign req_fall = !IRQ_REQUEST_IN & req_prev_q;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			req_prev_q <= 1'b0;
		end else begin
			req_prev_q <= IRQ_REQUEST_IN;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MSG_IRQ_REQUEST <= 1'b0;
			MSG_IRQ_ADDR    <= 64'h0;
			MSG_IRQ_DATA    <= 32'h0;
		end else begin
			MSG_IRQ_REQUEST <= ep_mode && msg_en && req_rise;
			if (ep_mode && msg_en && req_rise) begin
				MSG_IRQ_ADDR <= {msg_addr1_q, msg_addr0_q};
				MSG_IRQ_DATA <= msg_data_q;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			leg_q             <= LEG_IDLE;
			ASSERT_INTA_MSG   <= 1'b0;
			DEASSERT_INTA_MSG <= 1'b0;
		end else begin
			ASSERT_INTA_MSG   <= 1'b0;
			DEASSERT_INTA_MSG <= 1'b0;
			case (leg_q)
			LEG_IDLE: begin
				if (ep_mode && legacy_sel && !msg_en && req_rise) begin
					ASSERT_INTA_MSG <= 1'b1;
					leg_q           <= LEG_ASSERTED;
				end
			end
			LEG_ASSERTED: begin
				if (req_fall) begin
					DEASSERT_INTA_MSG <= 1'b1;
					leg_q             <= LEG_IDLE;
				end
			end
			default: begin
				leg_q <= LEG_IDLE;
			end
			endcase
		end
	end

	// ======================================================
	// malformed and poisoned tlp handling
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			FATAL_ERR_MSG     <= 1'b0;
			DROP_POISONED_TLP <= 1'b0;
		end else begin
			FATAL_ERR_MSG <= MALFORMED_TLP && ep_mode &&
			                 ctrl_q[CTRL_ERR_REP];
			DROP_POISONED_TLP <= POISONED_REQ && ROOT_COMPLEX_SELECT;
		end
	end

	// ======================================================
	// register read
	always_comb begin
		rdata_d = 32'h0;
		case (REG_ADDR)
		OFS_CTRL:      rdata_d = ctrl_q;
		OFS_DECODE:    rdata_d[DEC_W-1:0] = decode_q;
		OFS_MASK:      rdata_d[DEC_W-1:0] = mask_q;
		OFS_MSG_ADDR0: rdata_d = msg_addr0_q;
		OFS_MSG_ADDR1: rdata_d = msg_addr1_q;
		OFS_MSG_DATA:  rdata_d = msg_data_q;
		OFS_STATUS: begin
			rdata_d[STS_LEVEL]    = req_prev_q;
			rdata_d[STS_ASSERTED] = leg_q == LEG_ASSERTED;
			rdata_d[STS_RC]       = ROOT_COMPLEX_SELECT;
		end
		default: begin
			if (win_sel) begin
				rdata_d = win_ofs[WIN_HI_SEL] ?
				          xlate_q[32'(win_idx)*64+32 +: 32] :
				          xlate_q[32'(win_idx)*64 +: 32];
			end
		end
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_RDATA <= 32'h0;
		end else begin
			REG_RDATA <= REG_RD ? rdata_d : 32'h0;
		end
	end

	assign MSG_IRQ_ENABLED = msg_en;
	assign INTERRUPT_OUT   = irq_q;

	// ======================================================
	// translators
	bti_outbound #(
		.COUNT (NW),
		.BASE  (LOCAL_WINDOW_BASE),
		.HIGH  (LOCAL_WINDOW_HIGH),
		.WIDE  (LOCAL_WINDOW_WIDE_SPACE)
	) u_out (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.addr_in   (AXI_ADDR),
		.valid_in  (AXI_ADDR_VALID),
		.xlate_in  (xlate_q),
		.addr_out  (PCIE_ADDR),
		.hit_out   (PCIE_ADDR_HIT),
		.wide_out  (PCIE_ADDR_WIDE),
		.valid_out (PCIE_ADDR_VALID)
	);

	bti_inbound #(
		.COUNT (INBOUND_BAR_COUNT),
		.LEN   (INBOUND_BAR_LEN_BITS),
		.BASE  (INBOUND_BAR_XLATE_BASE)
	) u_in (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.addr_in   (RX_PCIE_ADDR),
		.bar_hit   (RX_BAR_HIT),
		.valid_in  (RX_ADDR_VALID),
		.addr_out  (RX_AXI_ADDR),
		.valid_out (RX_AXI_ADDR_VALID)
	);

	// ======================================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_fatal_gate: assert property (
		FATAL_ERR_MSG == $past(MALFORMED_TLP && ep_mode &&
		                       ctrl_q[CTRL_ERR_REP]))
		else $error("fatal message not tied to malformed tlp");

	a_poison_drop: assert property (
		POISONED_REQ && ROOT_COMPLEX_SELECT |=>
		DROP_POISONED_TLP && decode_q[DEC_POISON])
		else $error("poisoned request not dropped and flagged");

	a_msi_edge: assert property (
		ep_mode && msg_en && IRQ_REQUEST_IN && !req_prev_q |=>
		MSG_IRQ_REQUEST ##1 !MSG_IRQ_REQUEST)
		else $error("msg_irq_request not one pulse after rising edge");

	a_rc_ignores: assert property (
		ROOT_COMPLEX_SELECT |-> !MSG_IRQ_REQUEST && !ASSERT_INTA_MSG)
		else $error("request input acted on in root complex mode");

	a_inta_assert: assert property (
		leg_q == LEG_IDLE && ep_mode && legacy_sel && !msg_en &&
		$rose(IRQ_REQUEST_IN) |=> ASSERT_INTA_MSG && !DEASSERT_INTA_MSG)
		else $error("assert inta missing after rise");

	a_inta_deassert: assert property (
		leg_q == LEG_ASSERTED && $fell(IRQ_REQUEST_IN) |=>
		DEASSERT_INTA_MSG && leg_q == LEG_IDLE)
		else $error("deassert inta missing after fall");

	a_irq_masked: assert property (
		INTERRUPT_OUT |-> |($past(decode_q) & $past(mask_q)))
		else $error("interrupt out without unmasked source");

	a_msi_rc_only: assert property (
		!ROOT_COMPLEX_SELECT |-> !decode_q[DEC_MSG_RX] && !mask_q[DEC_MSG_RX])
		else $error("msi received source used in endpoint mode");

	a_set_wins: assert property (
		MALFORMED_TLP |=> decode_q[DEC_MALFORMED] ##1
		(decode_q[DEC_MALFORMED] ||
		 $past(REG_WR && REG_ADDR == OFS_DECODE &&
		       REG_WDATA[DEC_MALFORMED])))
		else $error("decode bit lost or not sticky");
endmodule

// file: verif/bti_far_end.sv
// far end: interrupt request level and tlp event pulses.
// assumes it is stepped from the block's clock.
`timescale 1ns/1ns
module bti_far_end (
	input  wire logic clk,
	output logic      irq_level,
	output logic      msg_rx,
	output logic      malformed,
	output logic      poisoned
);
	// =====
	// idle levels
	initial begin
		irq_level = 1'b0;
		msg_rx = 1'b0;
		malformed = 1'b0;
		poisoned = 1'b0;
	end
	// =====
	// request level, changed just after an edge
	task automatic set_level(input logic v);
		@(posedge clk);
		irq_level <= v;
	endtask
	// =====
	// one-cycle event: 0 msi received, 1 malformed, 2 poisoned
	task automatic pulse(input int k);
		@(posedge clk);
		msg_rx <= (k == 0);
		malformed <= (k == 1);
		poisoned <= (k == 2);
		@(posedge clk);
		msg_rx <= 1'b0;
		malformed <= 1'b0;
		poisoned <= 1'b0;
	endtask
endmodule

// file: verif/tb_bti_top.sv
// testbench: endpoint and root complex builds side by side.
// assumes the far-end model supplies request level and tlp events.
`timescale 1ns/1ns
module tb_bti_top;
	import bti_pkg::*;
	// =====
	// signals
	logic        clk, rst_n, wr, rd, av, rxv, hit, wide, pv, rxav;
	logic        irq, mrx, mal, poi;
	logic [7:0]  addr;
	logic [31:0] wdata, axa, rxa, mdata;
	logic [63:0] pa, rxpa, maddr;
	logic [2:0]  bhit;
	logic [1:0]  msien, msi, ast, dst, fat, drop, intr;
	logic [31:0] rdata [2];
	int          n_msi [2], n_ast [2], n_dst [2], n_fat [2], n_drop [2];
	int          miscompares = 0;
	int          checked = 0;
	// =====
	// endpoint and root complex builds
	bti_top #(.DYNAMIC_XLATE_SELECT(1'b1)) DUT (
		.CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata[0]), .AXI_ADDR(axa),
		.AXI_ADDR_VALID(av), .PCIE_ADDR(pa), .PCIE_ADDR_HIT(hit),
		.PCIE_ADDR_WIDE(wide), .PCIE_ADDR_VALID(pv), .RX_PCIE_ADDR(rxpa),
		.RX_BAR_HIT(bhit), .RX_ADDR_VALID(rxv), .RX_AXI_ADDR(rxa),
		.RX_AXI_ADDR_VALID(rxav), .IRQ_REQUEST_IN(irq),
		.MSG_IRQ_RECEIVED(mrx), .MALFORMED_TLP(mal), .POISONED_REQ(poi),
		.MSG_IRQ_ENABLED(msien[0]), .MSG_IRQ_REQUEST(msi[0]),
		.MSG_IRQ_ADDR(maddr), .MSG_IRQ_DATA(mdata),
		.ASSERT_INTA_MSG(ast[0]), .DEASSERT_INTA_MSG(dst[0]),
		.FATAL_ERR_MSG(fat[0]), .DROP_POISONED_TLP(drop[0]),
		.INTERRUPT_OUT(intr[0]));
	bti_top #(.ROOT_COMPLEX_SELECT(1'b1)) DUT_RC (
		.CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata[1]), .AXI_ADDR(axa),
		.AXI_ADDR_VALID(av), .PCIE_ADDR(), .PCIE_ADDR_HIT(),
		.PCIE_ADDR_WIDE(), .PCIE_ADDR_VALID(), .RX_PCIE_ADDR(rxpa),
		.RX_BAR_HIT(bhit), .RX_ADDR_VALID(rxv), .RX_AXI_ADDR(),
		.RX_AXI_ADDR_VALID(), .IRQ_REQUEST_IN(irq),
		.MSG_IRQ_RECEIVED(mrx), .MALFORMED_TLP(mal), .POISONED_REQ(poi),
		.MSG_IRQ_ENABLED(msien[1]), .MSG_IRQ_REQUEST(msi[1]),
		.MSG_IRQ_ADDR(), .MSG_IRQ_DATA(), .ASSERT_INTA_MSG(ast[1]),
		.DEASSERT_INTA_MSG(dst[1]), .FATAL_ERR_MSG(fat[1]),
		.DROP_POISONED_TLP(drop[1]), .INTERRUPT_OUT(intr[1]));
	bti_far_end FAR (.clk(clk), .irq_level(irq), .msg_rx(mrx),
		.malformed(mal), .poisoned(poi));
	// =====
	// clock and pulse counters
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			n_msi[i] += (msi[i] === 1'b1);
			n_ast[i] += (ast[i] === 1'b1);
			n_dst[i] += (dst[i] === 1'b1);
			n_fat[i] += (fat[i] === 1'b1);
			n_drop[i] += (drop[i] === 1'b1);
		end
	end
	// =====
	// shared tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e0,
		input logic [31:0] e1);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata[0], e0);
		chk(rdata[1], e1);
	endtask
	task automatic xl_out(input logic [31:0] a, input logic [63:0] e,
		input logic [1:0] hw);
		@(posedge clk);
		axa <= a;
		av <= 1'b1;
		@(posedge clk);
		av <= 1'b0;
		#1;
		chk(pa, e);
		chk({pv, hit, wide}, {1'b1, hw});
	endtask
	task automatic xl_in(input logic [63:0] a, input logic [2:0] h,
		input logic [31:0] e);
		@(posedge clk);
		rxpa <= a;
		bhit <= h;
		rxv <= 1'b1;
		@(posedge clk);
		rxv <= 1'b0;
		#1;
		chk({rxav, rxa}, {1'b1, e});
	endtask
	// =====
	// scenarios
	task automatic t_regs;
		reg_rd(OFS_CTRL, CTRL_RST, CTRL_RST);
		reg_rd(OFS_MSG_DATA, MSG_RST, MSG_RST);
		reg_rd(OFS_STATUS, 32'h0, 32'h1 << STS_RC);
		reg_wr(8'h3c, 32'hffff_ffff);
		reg_rd(8'h3c, 32'h0, 32'h0);
	endtask
	task automatic t_out;
		logic [31:0] a [8] = '{32'h1234_0abc, 32'h1234_ffff,
			32'habcd_f123, 32'habcd_e000, 32'hfffe_dcba, 32'h71,
			32'h1235_0000, 32'h80};
		logic [63:0] e [8] = '{64'h5671_0abc, 64'h5671_ffff,
			64'h5000_0000_fedc_1123, 64'h5000_0000_fedc_0000,
			64'h41fe_dcba, 64'h6000_0000_8765_43f1, 64'h0, 64'h0};
		logic [1:0] hw [8] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3,
			2'h0, 2'h0};
		for (int i = 0; i < 8; i++) begin
			xl_out(a[i], e[i], hw[i]);
		end
	endtask
	task automatic t_in_dyn;
		xl_in(64'h2000_0000_abcd_fff4, 3'h1, 32'h1234_7ff4);
		xl_in(64'ha000_0000_1235_fedc, 3'h2, 32'hfe35_fedc);
		reg_wr(OFS_WIN_FIRST, 32'h9abc_0000);
		reg_rd(OFS_WIN_FIRST, 32'h9abc_0000, 32'h5671_0000);
		xl_out(32'h1234_0abc, 64'h9abc_0abc, 2'h2);
		xl_in(64'h2000_0000_abcd_fff4, 3'h1, 32'h1234_7ff4);
	endtask
	task automatic t_msi;
		reg_wr(OFS_MSG_ADDR0, 32'hfee0_1000);
		reg_wr(OFS_MSG_ADDR1, 32'h1);
		reg_wr(OFS_MSG_DATA, 32'h4321);
		reg_wr(OFS_CTRL, 32'h1 << CTRL_MSG_EN);
		cyc(1);
		chk(msien, 2'h1);
		FAR.set_level(1'b1);
		cyc(3);
		chk(n_msi[0], 1);
		chk(maddr, 64'h1_fee0_1000);
		chk(mdata, 32'h4321);
		FAR.set_level(1'b0);
		cyc(3);
		chk(n_msi[0] + n_ast[0] + n_dst[0], 1);
		chk(n_msi[1], 0);
	endtask
	task automatic t_legacy;
		reg_wr(OFS_CTRL, 32'h0);
		FAR.set_level(1'b1);
		cyc(3);
		chk(n_ast[0], 0);
		FAR.set_level(1'b0);
		reg_wr(OFS_CTRL, 32'(PIN_INTA) << CTRL_PIN_LO);
		FAR.set_level(1'b1);
		cyc(3);
		chk(n_ast[0] + 2 * n_dst[0], 1);
		reg_rd(OFS_STATUS, 32'h3, 32'h5);
		FAR.set_level(1'b0);
		cyc(3);
		chk(n_dst[0], 1);
		chk(n_ast[1] + n_dst[1], 0);
	endtask
	task automatic t_err;
		FAR.pulse(1);
		cyc(2);
		chk(n_fat[0], 0);
		reg_wr(OFS_CTRL, 32'h1 << CTRL_ERR_REP);
		FAR.pulse(1);
		cyc(2);
		chk(n_fat[0] + 2 * n_fat[1], 1);
		reg_rd(OFS_DECODE, 32'h4, 32'h4);
	endtask
	task automatic t_irq;
		chk(intr, 2'h0);
		reg_wr(OFS_MASK, 32'h7);
		reg_rd(OFS_MASK, 32'h6, 32'h7);
		chk(intr, 2'h3);
		reg_wr(OFS_DECODE, 32'h7);
		cyc(2);
		chk(intr, 2'h0);
		FAR.pulse(0);
		cyc(2);
		chk(intr, 2'h2);
		reg_rd(OFS_DECODE, 32'h0, 32'h1 << DEC_MSG_RX);
		reg_wr(OFS_DECODE, 32'h7);
		FAR.pulse(2);
		cyc(2);
		chk(n_drop[1], 1);
		chk(n_drop[0], 0);
		chk(intr[1], 1'b1);
	endtask
	// =====
	// verdict
	task automatic complete_run;
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{rst_n, wr, rd, av, rxv, addr, wdata, axa, rxpa, bhit} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_out;
		t_in_dyn;
		t_msi;
		t_legacy;
		t_err;
		t_irq;
		complete_run;
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		complete_run;
	end
endmodule
